// File: opmode_pkg.sv
package opmode_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned E_HZ = 2_000_000;
	localparam logic [5:0] E_DIV_M1 = 6'(CLK_HZ / E_HZ - 1);
	localparam logic [5:0] E_HALF = 6'(CLK_HZ / E_HZ / 2);
	localparam logic [6:0] PROTECT_E_CYCLES = 7'h40;

	// Register indices; byte address is four times the index
	localparam logic [13:0] IDX_OPTION = 14'h1039;
	localparam logic [13:0] IDX_MODE_CTRL = 14'h103c;
	localparam logic [13:0] IDX_FACTORY_TEST = 14'h103e;
	localparam logic [13:0] IDX_CONFIG = 14'h103f;
	localparam logic [13:0] IDX_STATUS = 14'h1030;

	// factory_test_control fields
	localparam int TST_ILLEGAL_OPCODE = 7;
	localparam int TST_FLAGS_TO_PORT = 5;
	localparam int TST_CHAIN_BYPASS = 4;
	localparam int TST_RESET_DISABLE = 3;
	localparam int TST_FORCE_CLOCK_FAIL = 2;
	localparam int TST_FORCE_WATCHDOG = 1;
	localparam int TST_CONFIG_OVERRIDE = 0;
	localparam logic [7:0] TST_WRITE_MASK = 8'hbf;
	localparam logic [7:0] TST_RESET = 8'h00;

	// mode_control fields
	localparam int MC_BOOTLOADER_ENABLE = 7;
	localparam int MC_SPECIAL_PRIVILEGE = 6;
	localparam int MC_EXPANSION_BUS = 5;
	localparam int MC_READ_VISIBILITY = 4;

	// configuration fields (nonvolatile image)
	localparam int CFG_WATCHDOG_DISABLE = 2;
	localparam int CFG_PROGRAM_MEMORY = 1;
	localparam int CFG_DATA_MEMORY = 0;
	localparam logic [2:0] CFG_RESET = 3'h3;

	// option fields
	localparam int OPT_CLOCK_MONITOR = 3;
	localparam logic [1:0] OPT_RATE_RESET = 2'h0;

	// Vector block bases
	localparam logic [15:0] VEC_NORMAL = 16'hffc0;
	localparam logic [15:0] VEC_SPECIAL = 16'hbfc0;
	localparam logic [15:0] BOOT_ROM_BASE = 16'hbf40;

	localparam logic [1:0] SRC_INTERNAL = 2'h0;
	localparam logic [1:0] SRC_EXTERNAL = 2'h1;
	localparam logic [1:0] SRC_BOOT_ROM = 2'h2;

	typedef enum logic [1:0] {
		ST_SYNC1 = 2'b00,
		ST_SYNC2 = 2'b01,
		ST_CAPTURE = 2'b11,
		ST_RUN = 2'b10
	} init_e;
endpackage

// File: operating_mode_test_control.sv
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
module operating_mode_test_control
	import opmode_pkg::*;
(
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic [15:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [31:0] writedata_i,
	input wire logic [3:0] byteenable_i,
	output logic [31:0] readdata_o,
	output logic waitrequest_o,
	input wire logic mode_pin_a_i,
	input wire logic mode_pin_b_i,
	input wire logic [4:0] cpu_flags_i,
	input wire logic illegal_opcode_i,
	input wire logic instruction_fetch_indicator_i,
	input wire logic watchdog_timeout_i,
	input wire logic clock_fail_i,
	output logic e_clock_o,
	output logic e_enable_o,
	output logic special_privilege_flag_o,
	output logic expansion_bus_enable_o,
	output logic bootloader_enable_o,
	output logic internal_read_visibility_o,
	output logic gpio_ports_free_o,
	output logic [15:0] vector_base_o,
	output logic [1:0] reset_vector_source_o,
	output logic program_memory_mapped_o,
	output logic bootloader_mapped_o,
	output logic data_memory_mapped_o,
	output logic watchdog_enable_o,
	output logic [1:0] watchdog_rate_o,
	output logic clock_monitor_enable_o,
	output logic illegal_opcode_test_o,
	output logic address_decrement_o,
	output logic flags_to_port_output_o,
	output logic [4:0] port_a_flags_o,
	output logic timer_chain_bypass_o,
	output logic prescaler_bypass_o,
	output logic watchdog_reset_o,
	output logic clock_monitor_reset_o
);
	init_e state_ff;
	logic [1:0] meta_ff;
	logic [1:0] sync_ff;
	logic [5:0] ediv_ff;
	logic e_en_ff;
	logic e_clk_ff;
	logic [6:0] ecnt_ff;
	logic wait_ff;
	logic [31:0] rdata_ff;
	logic special_privilege_flag_ff;
	logic mda_ff;
	logic irv_ff;
	logic bootloader_enable_ff;
	logic [7:0] test_ff;
	logic [2:0] cfg_ff;
	logic cme_ff;
	logic [1:0] rate_ff;
	logic rate_once_ff;
	logic addr_dec_ff;
	logic prog_map_ff;
	logic data_map_ff;
	logic wdog_en_ff;
	logic [1:0] vsrc_ff;
	logic wd_reset_ff;
	logic cm_reset_ff;
	logic [4:0] flags_ff;
	logic running;
	logic [13:0] idx;
	logic wr_go;
	logic wr_test;
	logic reset_disable_eff;
	logic rate_write_ok;
	logic [7:0] rd_byte;
	logic [7:0] wd;
	logic nxt_prog_map;

	assign running = (state_ff == ST_RUN);
	assign idx = address_i[15:2];
	assign wd = writedata_i[7:0];
	// Write lands only at the edge where the master sees waitrequest low
	assign wr_go = write_i && !wait_ff && byteenable_i[0];
	assign wr_test = wr_go && (idx == IDX_FACTORY_TEST) && special_privilege_flag_ff;
	assign reset_disable_eff = wr_test ? wd[TST_RESET_DISABLE] : test_ff[TST_RESET_DISABLE];
	// Normal modes: early window and only once; special lifts both
	assign rate_write_ok = special_privilege_flag_ff || ((ecnt_ff < PROTECT_E_CYCLES) && !rate_once_ff);

	// Pins are asynchronous to mclk
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			meta_ff <= 2'h0;
			sync_ff <= 2'h0;
		end else begin
			meta_ff <= {mode_pin_b_i, mode_pin_a_i};
			sync_ff <= meta_ff;
		end
	end

	// Two edges to settle the synchroniser, then one capture
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_ff <= ST_SYNC1;
		end else begin
			unique case (state_ff)
				ST_SYNC1: state_ff <= ST_SYNC2;
				ST_SYNC2: state_ff <= ST_CAPTURE;
				ST_CAPTURE: state_ff <= ST_RUN;
				ST_RUN: state_ff <= ST_RUN;
			endcase
		end
	end

	// E clock as an enable; bus wait states never depend on it
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ediv_ff <= 6'h00;
			e_en_ff <= 1'b0;
			e_clk_ff <= 1'b0;
		end else begin
			ediv_ff <= (ediv_ff == E_DIV_M1) ? 6'h00 : ediv_ff + 6'h01;
			e_en_ff <= (ediv_ff == E_DIV_M1);
			e_clk_ff <= (ediv_ff >= E_HALF);
		end
	end

	// Saturating count of E cycles since reset
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ecnt_ff <= 7'h00;
		end else if (e_en_ff && (ecnt_ff < PROTECT_E_CYCLES)) begin
			ecnt_ff <= ecnt_ff + 7'h01;
		end
	end

	always_comb begin
		rd_byte = 8'h00;
		unique case (idx)
			IDX_FACTORY_TEST: rd_byte = special_privilege_flag_ff ? test_ff : 8'h00;
			IDX_MODE_CTRL: rd_byte = {bootloader_enable_ff, special_privilege_flag_ff, mda_ff, irv_ff, 4'h0};
			IDX_CONFIG: rd_byte = {5'h00, cfg_ff};
			IDX_OPTION: rd_byte = {4'h0, cme_ff, 1'b0, rate_ff};
			IDX_STATUS: rd_byte = {prog_map_ff, data_map_ff, wdog_en_ff, addr_dec_ff,
				vsrc_ff, ~special_privilege_flag_ff, mda_ff};
			default: rd_byte = 8'h00;
		endcase
	end

	// Once running, every request answered one cycle after it is seen, unmapped too
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wait_ff <= 1'b1;
			rdata_ff <= 32'h0;
		end else if (!wait_ff) begin
			wait_ff <= 1'b1;
		end else if ((read_i || write_i) && running) begin
			wait_ff <= 1'b0;
			rdata_ff <= {24'h0, rd_byte};
		end
	end

	// Mode state: strap capture, then privileged writes; privilege and read visibility only clear
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			special_privilege_flag_ff <= 1'b0;
			mda_ff <= 1'b0;
			irv_ff <= 1'b0;
			bootloader_enable_ff <= 1'b0;
		end else if (state_ff == ST_CAPTURE) begin
			special_privilege_flag_ff <= !sync_ff[1];
			mda_ff <= sync_ff[0];
			irv_ff <= !sync_ff[1];
			bootloader_enable_ff <= !sync_ff[1] && !sync_ff[0];
		end else if (wr_go && (idx == IDX_MODE_CTRL) && special_privilege_flag_ff) begin
			special_privilege_flag_ff <= special_privilege_flag_ff && wd[MC_SPECIAL_PRIVILEGE];
			irv_ff <= irv_ff && wd[MC_READ_VISIBILITY];
			bootloader_enable_ff <= wd[MC_BOOTLOADER_ENABLE];
			mda_ff <= wd[MC_EXPANSION_BUS];
		end
	end

	// Factory test register; cleared on the edge after privilege goes
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			test_ff <= TST_RESET;
		end else if (state_ff == ST_CAPTURE) begin
			test_ff <= TST_RESET;
			test_ff[TST_RESET_DISABLE] <= !sync_ff[1];
		end else if (!special_privilege_flag_ff) begin
			test_ff <= TST_RESET;
		end else if (wr_test) begin
			test_ff <= wd & TST_WRITE_MASK;
		end
	end

	// Nonvolatile image stands in for the programmed cells
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cfg_ff <= CFG_RESET;
		end else if (wr_go && (idx == IDX_CONFIG) && special_privilege_flag_ff) begin
			cfg_ff <= wd[2:0];
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cme_ff <= 1'b0;
			rate_ff <= OPT_RATE_RESET;
			rate_once_ff <= 1'b0;
		end else if (wr_go && (idx == IDX_OPTION)) begin
			cme_ff <= wd[OPT_CLOCK_MONITOR];
			if (rate_write_ok) begin
				rate_ff <= wd[1:0];
				rate_once_ff <= 1'b1;
			end
		end
	end

	// Address runs backwards once an illegal opcode is fetched
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			addr_dec_ff <= 1'b0;
		end else if (!test_ff[TST_ILLEGAL_OPCODE]) begin
			addr_dec_ff <= 1'b0;
		end else if (illegal_opcode_i && instruction_fetch_indicator_i) begin
			addr_dec_ff <= 1'b1;
		end
	end

	// Flags path removes program memory before anything else
	always_comb begin
		if (test_ff[TST_FLAGS_TO_PORT]) begin
			nxt_prog_map = 1'b0;
		end else if (test_ff[TST_CONFIG_OVERRIDE]) begin
			nxt_prog_map = 1'b1;
		end else if (!special_privilege_flag_ff && !mda_ff) begin
			nxt_prog_map = 1'b1;
		end else begin
			nxt_prog_map = cfg_ff[CFG_PROGRAM_MEMORY];
		end
	end

	// Registered decode so every output leaves a flip-flop
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			prog_map_ff <= 1'b0;
			data_map_ff <= 1'b0;
			wdog_en_ff <= 1'b0;
			vsrc_ff <= SRC_INTERNAL;
			flags_ff <= 5'h00;
		end else begin
			prog_map_ff <= nxt_prog_map;
			data_map_ff <= cfg_ff[CFG_DATA_MEMORY] || test_ff[TST_CONFIG_OVERRIDE];
			wdog_en_ff <= !cfg_ff[CFG_WATCHDOG_DISABLE] || test_ff[TST_CONFIG_OVERRIDE];
			flags_ff <= test_ff[TST_FLAGS_TO_PORT] ? cpu_flags_i : 5'h00;
			if (special_privilege_flag_ff) begin
				vsrc_ff <= bootloader_enable_ff ? SRC_BOOT_ROM : SRC_EXTERNAL;
			end else begin
				vsrc_ff <= nxt_prog_map ? SRC_INTERNAL : SRC_EXTERNAL;
			end
		end
	end

	// Reset-disable has the last word over forced and real failures
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wd_reset_ff <= 1'b0;
			cm_reset_ff <= 1'b0;
		end else begin
			wd_reset_ff <= !reset_disable_eff && (wdog_en_ff || test_ff[TST_CONFIG_OVERRIDE]) &&
				((wr_test && wd[TST_FORCE_WATCHDOG]) || watchdog_timeout_i);
			cm_reset_ff <= !reset_disable_eff && cme_ff &&
				((wr_test && wd[TST_FORCE_CLOCK_FAIL]) || clock_fail_i);
		end
	end

	assign readdata_o = rdata_ff;
	assign waitrequest_o = wait_ff;
	assign e_clock_o = e_clk_ff;
	assign e_enable_o = e_en_ff;
	assign special_privilege_flag_o = special_privilege_flag_ff;
	assign expansion_bus_enable_o = mda_ff;
	assign bootloader_enable_o = bootloader_enable_ff;
	assign bootloader_mapped_o = bootloader_enable_ff;
	assign internal_read_visibility_o = irv_ff;
	assign watchdog_rate_o = rate_ff;
	assign clock_monitor_enable_o = cme_ff;
	assign illegal_opcode_test_o = test_ff[TST_ILLEGAL_OPCODE];
	assign address_decrement_o = addr_dec_ff;
	assign flags_to_port_output_o = test_ff[TST_FLAGS_TO_PORT];
	assign port_a_flags_o = flags_ff;
	assign timer_chain_bypass_o = test_ff[TST_CHAIN_BYPASS];
	assign prescaler_bypass_o = test_ff[TST_CHAIN_BYPASS];
	assign program_memory_mapped_o = prog_map_ff;
	assign data_memory_mapped_o = data_map_ff;
	assign watchdog_enable_o = wdog_en_ff;
	assign reset_vector_source_o = vsrc_ff;
	assign watchdog_reset_o = wd_reset_ff;
	assign clock_monitor_reset_o = cm_reset_ff;

	// Vector block and port freeing follow live mode state
	logic [15:0] vbase_ff;
	logic gpio_ff;
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			vbase_ff <= VEC_NORMAL;
			gpio_ff <= 1'b0;
		end else begin
			vbase_ff <= special_privilege_flag_ff ? VEC_SPECIAL : VEC_NORMAL;
			gpio_ff <= !mda_ff;
		end
	end
	assign vector_base_o = vbase_ff;
	assign gpio_ports_free_o = gpio_ff;

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!resetn_i);

	a_ack_one_cycle: assert property ($fell(waitrequest_o) |=> waitrequest_o)
		else $error("waitrequest low for more than one cycle");
	a_req_answered: assert property (
		(read_i || write_i) && waitrequest_o && running |=> !waitrequest_o)
		else $error("request not answered next cycle");
	a_priv_no_set: assert property (running && !special_privilege_flag_ff |=> !special_privilege_flag_ff)
		else $error("privilege flag set again");
	a_irv_no_set: assert property (running && !irv_ff |=> !irv_ff)
		else $error("read visibility set again");
	a_strap_capture: assert property (
		state_ff == ST_CAPTURE |=> special_privilege_flag_ff == !$past(sync_ff[1]) && mda_ff == $past(sync_ff[0]))
		else $error("mode not captured from pins");
	a_test_cleared: assert property (running && !special_privilege_flag_ff |=> test_ff == TST_RESET)
		else $error("test register not cleared in normal mode");
	a_reset_disable_special: assert property (
		state_ff == ST_CAPTURE && !sync_ff[1] |=> test_ff[TST_RESET_DISABLE])
		else $error("reset-disable not set after special reset");
	a_fcm_reset: assert property (
		wr_test && wd[TST_FORCE_CLOCK_FAIL] && cme_ff && !wd[TST_RESET_DISABLE]
		|=> clock_monitor_reset_o)
		else $error("forced clock failure gave no reset");
	a_reset_disable_blocks: assert property (
		test_ff[TST_RESET_DISABLE] && !wr_test |=> !watchdog_reset_o && !clock_monitor_reset_o)
		else $error("reset passed while reset-disable set");
	a_flags_unmap: assert property (
		test_ff[TST_FLAGS_TO_PORT] |=> !program_memory_mapped_o)
		else $error("program memory mapped while flags driven");
	a_single_chip_rom: assert property (
		running && !special_privilege_flag_ff && !mda_ff && !test_ff[TST_FLAGS_TO_PORT] |=> program_memory_mapped_o)
		else $error("single-chip without program memory");
	a_rate_locked: assert property (
		!special_privilege_flag_ff && rate_once_ff && wr_go && idx == IDX_OPTION |=> $stable(rate_ff))
		else $error("protected rate bits rewritten");
endmodule // operating_mode_test_control

// File: expansion_peer_model.sv
`timescale 1ns/1ps
module expansion_peer_model (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic e_enable_i,
	input wire logic [1:0] fail_req_i,
	output logic [4:0] cpu_flags_o,
	output logic watchdog_timeout_o,
	output logic clock_fail_o
);
	// Flags step every E cycle so a stale copy cannot pass
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cpu_flags_o <= 5'h15;
		end else if (e_enable_i) begin
			cpu_flags_o <= {cpu_flags_o[3:0], ~cpu_flags_o[4]};
		end
	end
	// Answers within one E cycle, never later
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			{watchdog_timeout_o, clock_fail_o} <= 2'h0;
		end else if (e_enable_i) begin
			{watchdog_timeout_o, clock_fail_o} <= fail_req_i;
		end
	end
endmodule // expansion_peer_model

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import opmode_pkg::*;
	localparam logic [15:0] A_OPT = {IDX_OPTION, 2'b00};
	localparam logic [15:0] A_MC = {IDX_MODE_CTRL, 2'b00};
	localparam logic [15:0] A_TST = {IDX_FACTORY_TEST, 2'b00};
	localparam logic [15:0] A_CFG = {IDX_CONFIG, 2'b00};
	logic mclk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [15:0] address_i = 16'h0;
	logic read_i = 1'b0, write_i = 1'b0, mode_pin_a_i = 1'b0, mode_pin_b_i = 1'b0;
	logic [31:0] writedata_i = 32'h0;
	logic [3:0] byteenable_i = 4'h1;
	logic illegal_opcode_i = 1'b0, instruction_fetch_indicator_i = 1'b0;
	logic [1:0] fail_req = 2'h0;
	logic [31:0] readdata_o, rd;
	logic [4:0] cpu_flags_i, port_a_flags_o, prev;
	logic [15:0] vector_base_o;
	logic [1:0] reset_vector_source_o, watchdog_rate_o;
	logic waitrequest_o, watchdog_timeout_i, clock_fail_i, e_clock_o, e_enable_o;
	logic special_privilege_flag_o, expansion_bus_enable_o, bootloader_enable_o;
	logic internal_read_visibility_o, gpio_ports_free_o, program_memory_mapped_o;
	logic bootloader_mapped_o, data_memory_mapped_o, watchdog_enable_o;
	logic clock_monitor_enable_o, illegal_opcode_test_o, address_decrement_o;
	logic flags_to_port_output_o, timer_chain_bypass_o, prescaler_bypass_o;
	logic watchdog_reset_o, clock_monitor_reset_o;
	int mismatches = 0, tests_run = 0, wd_n = 0, cm_n = 0;
	int e_n = 0, eh_n = 0, e0 = 0, h0 = 0;

	always #5 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		wd_n <= wd_n + int'(watchdog_reset_o === 1'b1);
		cm_n <= cm_n + int'(clock_monitor_reset_o === 1'b1);
		e_n <= e_n + int'(e_enable_o === 1'b1);
		eh_n <= eh_n + int'(e_clock_o === 1'b1);
	end

	operating_mode_test_control operating_mode_test_control_inst (.*);
	expansion_peer_model expansion_peer_model_inst (.mclk_i(mclk_i), .resetn_i(resetn_i),
		.e_enable_i(e_enable_o), .fail_req_i(fail_req), .cpu_flags_o(cpu_flags_i),
		.watchdog_timeout_o(watchdog_timeout_i), .clock_fail_o(clock_fail_i));

	task automatic tally_and_finish();
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] d);
		int n;
		@(posedge mclk_i);
		address_i <= a;
		writedata_i <= {24'h0, d};
		read_i <= !wr;
		write_i <= wr;
		for (n = 0; n < 50; n++) begin
			@(posedge mclk_i);
			if (waitrequest_o === 1'b0) break;
		end
		rd = readdata_o;
		read_i <= 1'b0;
		write_i <= 1'b0;
		if (n == 50) begin
			mismatches++;
			$display("mismatch at %0t: bus answer timeout", $time);
			tally_and_finish();
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdc(input logic [15:0] a, input logic [31:0] exp);
		bus(1'b0, a, 8'h0);
		chk(rd, exp);
	endtask
	task automatic boot(input logic b, input logic a);
		@(posedge mclk_i);
		resetn_i <= 1'b0;
		mode_pin_b_i <= b;
		mode_pin_a_i <= a;
		repeat (4) @(posedge mclk_i);
		resetn_i <= 1'b1;
		repeat (6) @(posedge mclk_i);
		@(negedge mclk_i);
	endtask
	// Long enough for one E cycle to pass through the peer
	task automatic settle();
		repeat (60) @(posedge mclk_i);
		@(negedge mclk_i);
	endtask

	initial begin
		boot(1'b1, 1'b0);
		chk(vector_base_o, VEC_NORMAL);
		chk(gpio_ports_free_o, 1'b1);
		chk(program_memory_mapped_o, 1'b1);
		chk(special_privilege_flag_o, 1'b0);
		wr(A_TST, 8'hbf);
		rdc(A_TST, 32'h0);
		wr(A_CFG, 8'h00);
		rdc(A_CFG, 32'h3);
		wr(A_OPT, 8'h02);
		wr(A_OPT, 8'h0b);
		rdc(A_OPT, 32'h0a);
		rdc(16'h4000, 32'h0);
		mode_pin_b_i <= 1'b0;
		settle();
		chk(vector_base_o, VEC_NORMAL);
		chk(watchdog_rate_o, 2'h2);
		// One full divider period: one enable pulse, half of it high
		e0 = e_n;
		h0 = eh_n;
		repeat (50) @(negedge mclk_i);
		chk(e_n - e0, 1);
		chk(eh_n - h0, 25);
		$display("test single_chip done");

		boot(1'b1, 1'b1);
		chk(expansion_bus_enable_o, 1'b1);
		chk(gpio_ports_free_o, 1'b0);
		chk(program_memory_mapped_o, 1'b1);
		chk(reset_vector_source_o, SRC_INTERNAL);
		// Past 64 E cycles the protected rate must refuse
		repeat (3300) @(posedge mclk_i);
		wr(A_OPT, 8'h03);
		rdc(A_OPT, 32'h0);
		$display("test expanded done");

		boot(1'b0, 1'b0);
		chk(vector_base_o, VEC_SPECIAL);
		chk(reset_vector_source_o, SRC_BOOT_ROM);
		chk(bootloader_mapped_o, 1'b1);
		chk(special_privilege_flag_o, 1'b1);
		rdc({IDX_STATUS, 2'b00}, 32'he8);
		rdc(A_TST, 32'h08);
		wr(A_OPT, 8'h08);
		wr(A_OPT, 8'h01);
		wr(A_OPT, 8'h0a);
		rdc(A_OPT, 32'h0a);
		chk(clock_monitor_enable_o, 1'b1);
		wr(A_CFG, 8'h04);
		rdc(A_CFG, 32'h04);
		// Low byte lane off: the write must be ignored
		byteenable_i <= 4'h0;
		wr(A_CFG, 8'h03);
		byteenable_i <= 4'h1;
		rdc(A_CFG, 32'h04);
		fail_req <= 2'h3;
		settle();
		wr(A_TST, 8'h0e);
		fail_req <= 2'h0;
		settle();
		chk(wd_n + cm_n, 0);
		wr(A_TST, 8'h02);
		settle();
		chk(wd_n, 0);
		wr(A_TST, 8'h04);
		settle();
		chk(cm_n, 1);
		// Override must already stand when the forcing write lands
		wr(A_TST, 8'h01);
		wr(A_TST, 8'h03);
		settle();
		chk(wd_n, 1);
		chk({watchdog_enable_o, data_memory_mapped_o, program_memory_mapped_o}, 3'h7);
		wr(A_TST, 8'h21);
		settle();
		chk({flags_to_port_output_o, program_memory_mapped_o}, 2'h2);
		prev = cpu_flags_i;
		@(negedge mclk_i);
		chk(port_a_flags_o, prev);
		wr(A_TST, 8'h90);
		illegal_opcode_i <= 1'b1;
		instruction_fetch_indicator_i <= 1'b1;
		settle();
		illegal_opcode_i <= 1'b0;
		instruction_fetch_indicator_i <= 1'b0;
		settle();
		chk({illegal_opcode_test_o, address_decrement_o}, 2'h3);
		chk({timer_chain_bypass_o, prescaler_bypass_o}, 2'h3);
		chk({flags_to_port_output_o, port_a_flags_o}, 6'h0);
		wr(A_TST, 8'h00);
		settle();
		chk(address_decrement_o, 1'b0);
		wr(A_TST, 8'h08);
		wr(A_MC, 8'h20);
		settle();
		chk({special_privilege_flag_o, internal_read_visibility_o}, 2'h0);
		chk({expansion_bus_enable_o, bootloader_enable_o}, 2'h2);
		chk(vector_base_o, VEC_NORMAL);
		chk(program_memory_mapped_o, 1'b0);
		rdc(A_TST, 32'h0);
		wr(A_MC, 8'hd0);
		rdc(A_MC, 32'h20);
		fail_req <= 2'h1;
		settle();
		chk(clock_monitor_reset_o, 1'b1);
		fail_req <= 2'h0;
		$display("test bootstrap done");

		boot(1'b0, 1'b1);
		chk(vector_base_o, VEC_SPECIAL);
		chk(reset_vector_source_o, SRC_EXTERNAL);
		chk(bootloader_enable_o, 1'b0);
		rdc(A_TST, 32'h08);
		$display("test special_test done");
		tally_and_finish();
	end
endmodule // tb_top
